// [include/cpu_ext_exec_regs.svh]
/*
  Constants for the extended-instruction execution core: opcode encodings,
  field positions, reset values, the port high byte and step sizes.
  Assumes it is included by its bare name after the package.
*/
`ifndef CPU_EXT_EXEC_REGS_SVH
`define CPU_EXT_EXEC_REGS_SVH

// ==========================================================
// opcodes
`define OP_PREFIX      8'hed
`define OP_SWAP_AF     8'h08
`define OP_SWAP_GEN    8'hd9
`define OP_SLEEP       8'h76
`define OP_MUL_MASK    8'hcf
`define OP_MUL         8'h4c
`define OP_BLK_MASK    8'he7
`define OP_BLK         8'h83
`define OP_PORT_TEST   8'h74
`define OP_IMM_TEST    8'h64
`define OP_MEM_TEST    8'h34
`define OP_G_MASK      8'hc7
`define OP_IN_IMM      8'h00
`define OP_OUT_IMM     8'h01
`define OP_REG_TEST    8'h04

// ==========================================================
// fields
`define REG_G_MEM      3'h6
`define BLK_REPEAT_BIT 4
`define BLK_DEC_BIT    3
`define F_SIGN         7
`define F_ZERO         6
`define F_HALF         4
`define F_PARITY       2
`define F_NEG          1
`define F_CARRY        0

// ==========================================================
// values
`define IO_HIGH_BYTE   8'h00
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define RFSH_STEP      7'h01
`define STEP_WORD      16'h0001
`define STEP_BYTE      8'h01

`endif

// [include/cpu_ext_exec_pkg.sv]
/*
  Types for the extended-instruction execution core.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cpu_ext_exec_pkg;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'h0,
    ST_PREFIX = 3'h1,
    ST_IMM    = 3'h2,
    ST_MEMRD  = 3'h3,
    ST_IORD   = 3'h4,
    ST_IOWR   = 3'h5,
    ST_SLEEP  = 3'h6
  } exec_state_e;

  typedef enum logic [2:0] {
    IK_NONE   = 3'h0,
    IK_BLOCK  = 3'h1,
    IK_PORT_TEST = 3'h2,
    IK_TSTM   = 3'h3,
    IK_TSTHL  = 3'h4,
    IK_IN0    = 3'h5,
    IK_OUT0   = 3'h6
  } instr_kind_e;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] f;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] h;
    logic [7:0] l;
  } gset_s;

  typedef struct packed {
    logic [7:0]  vector_base;
    logic [7:0]  refresh;
    logic [15:0] first_index;
    logic [15:0] second_index;
    logic [15:0] stack_top;
    logic [15:0] instruction_address;
  } special_s;

  typedef struct packed {
    logic        req;
    logic        m1;
    logic        io;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bus_s;

endpackage

// [rtl/cpu_extended_instruction_exec.sv]
/*
  Execution core for the added instructions of an 8-bit processor, with the
  primary, shadow and special register sets.
  Assumes memory and I/O peripherals on the same clock answer each bus
  request with bus_ack_in held until the request drops.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ext_exec_regs.svh"

module cpu_extended_instruction_exec
  import cpu_ext_exec_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       wake_in,
  input  wire logic [7:0] bus_rdata_in,
  input  wire logic       bus_ack_in,
  output logic            sys_clk_out,
  output bus_s            bus_out,
  output logic            sleep_out,
  output gset_s           primary_out,
  output special_s        special_out
);

  // ==========================================================
  // helpers
  function automatic logic [7:0] get_reg(input gset_s s, input logic [2:0] g);
    case (g)
      3'h0:    get_reg = s.b;
      3'h1:    get_reg = s.c;
      3'h2:    get_reg = s.d;
      3'h3:    get_reg = s.e;
      3'h4:    get_reg = s.h;
      3'h5:    get_reg = s.l;
      3'h7:    get_reg = s.a;
      default: get_reg = `RST_BYTE;
    endcase
  endfunction

  function automatic gset_s set_reg(input gset_s s, input logic [2:0] g,
                                    input logic [7:0] v);
    gset_s r;
    r = s;
    case (g)
      3'h0:    r.b = v;
      3'h1:    r.c = v;
      3'h2:    r.d = v;
      3'h3:    r.e = v;
      3'h4:    r.h = v;
      3'h5:    r.l = v;
      3'h7:    r.a = v;
      default: r = s;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] and_flags(input logic [7:0] f, input logic [7:0] r);
    logic [7:0] n;
    n = f;
    n[`F_SIGN]   = r[7];
    n[`F_ZERO]   = (r == `RST_BYTE);
    n[`F_HALF]   = 1'b1;
    n[`F_PARITY] = ~^r;
    n[`F_NEG]    = 1'b0;
    n[`F_CARRY]  = 1'b0;
    return n;
  endfunction

  function automatic logic [15:0] mul8(input logic [7:0] x, input logic [7:0] y);
    return {8'h00, x} * {8'h00, y};
  endfunction

  // ==========================================================
  // system clock divider
  logic phi_en;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sys_clk_out <= 1'b0;
    end else begin
      sys_clk_out <= ~sys_clk_out;
    end
  end

  // one step of the core per two input clocks
  assign phi_en = sys_clk_out;

  // ==========================================================
  // wake pin synchroniser
  logic wake_meta;
  logic wake_sync;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake_in;
      wake_sync <= wake_meta;
    end
  end

  // ==========================================================
  // bus request for the current state
  exec_state_e state;
  instr_kind_e kind;
  gset_s       shadow;
  logic [7:0]  op2;
  logic [7:0]  imm;
  bus_s        next_bus;
  logic        bus_state;
  logic        bus_done;

  always_comb begin
    next_bus     = '0;
    next_bus.req = 1'b1;
    bus_state    = 1'b1;
    case (state)
      ST_FETCH, ST_PREFIX: begin
        next_bus.m1   = 1'b1;
        next_bus.addr = special_out.instruction_address;
      end
      ST_IMM: begin
        next_bus.addr = special_out.instruction_address;
      end
      ST_MEMRD: begin
        next_bus.addr = {primary_out.h, primary_out.l};
      end
      ST_IORD: begin
        next_bus.io   = 1'b1;
        next_bus.addr = {`IO_HIGH_BYTE,
                         (kind == IK_IN0) ? imm : primary_out.c};
      end
      ST_IOWR: begin
        next_bus.io    = 1'b1;
        next_bus.we    = 1'b1;
        next_bus.addr  = {`IO_HIGH_BYTE,
                          (kind == IK_OUT0) ? imm : primary_out.c};
        next_bus.wdata = (kind == IK_OUT0) ? get_reg(primary_out, op2[5:3]) : imm;
      end
      default: begin
        next_bus  = '0;
        bus_state = 1'b0;
      end
    endcase
  end

  assign bus_done = bus_out.req && bus_ack_in;

  // ==========================================================
  // sequencer and register sets
  logic [7:0] blk_b;
  logic       blk_dec;

  assign blk_b   = primary_out.b - `STEP_BYTE;
  assign blk_dec = op2[`BLK_DEC_BIT];

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state       <= ST_FETCH;
      kind        <= IK_NONE;
      op2         <= `RST_BYTE;
      imm         <= `RST_BYTE;
      bus_out     <= '0;
      sleep_out   <= 1'b0;
      primary_out <= '0;
      shadow      <= '0;
      special_out <= '0;
    end else if (phi_en) begin
      if (bus_state && !bus_out.req) begin
        bus_out <= next_bus;
      end else if (bus_done) begin
        bus_out <= '0;
        case (state)
          ST_FETCH: begin
            special_out.instruction_address <=
              special_out.instruction_address + `STEP_WORD;
            special_out.refresh[6:0] <= special_out.refresh[6:0] + `RFSH_STEP;
            if (bus_rdata_in == `OP_PREFIX) begin
              state <= ST_PREFIX;
            end else if (bus_rdata_in == `OP_SWAP_AF) begin
              {primary_out.a, primary_out.f} <= {shadow.a, shadow.f};
              {shadow.a, shadow.f}           <= {primary_out.a, primary_out.f};
            end else if (bus_rdata_in == `OP_SWAP_GEN) begin
              {primary_out.b, primary_out.c, primary_out.d, primary_out.e,
               primary_out.h, primary_out.l} <=
                {shadow.b, shadow.c, shadow.d, shadow.e, shadow.h, shadow.l};
              {shadow.b, shadow.c, shadow.d, shadow.e, shadow.h, shadow.l} <=
                {primary_out.b, primary_out.c, primary_out.d, primary_out.e,
                 primary_out.h, primary_out.l};
            end
          end
          ST_PREFIX: begin
            special_out.instruction_address <=
              special_out.instruction_address + `STEP_WORD;
            special_out.refresh[6:0] <= special_out.refresh[6:0] + `RFSH_STEP;
            op2   <= bus_rdata_in;
            state <= ST_FETCH;
            kind  <= IK_NONE;
            if (bus_rdata_in == `OP_SLEEP) begin
              state     <= ST_SLEEP;
              sleep_out <= 1'b1;
            end else if ((bus_rdata_in & `OP_MUL_MASK) == `OP_MUL) begin
              case (bus_rdata_in[5:4])
                2'h0: {primary_out.b, primary_out.c} <= mul8(primary_out.b, primary_out.c);
                2'h1: {primary_out.d, primary_out.e} <= mul8(primary_out.d, primary_out.e);
                2'h2: {primary_out.h, primary_out.l} <= mul8(primary_out.h, primary_out.l);
                default: special_out.stack_top <=
                  mul8(special_out.stack_top[15:8], special_out.stack_top[7:0]);
              endcase
            end else if ((bus_rdata_in & `OP_BLK_MASK) == `OP_BLK) begin
              kind  <= IK_BLOCK;
              state <= ST_MEMRD;
            end else if (bus_rdata_in == `OP_PORT_TEST) begin
              kind  <= IK_PORT_TEST;
              state <= ST_IMM;
            end else if (bus_rdata_in == `OP_IMM_TEST) begin
              kind  <= IK_TSTM;
              state <= ST_IMM;
            end else if (bus_rdata_in == `OP_MEM_TEST) begin
              kind  <= IK_TSTHL;
              state <= ST_MEMRD;
            end else if (bus_rdata_in[5:3] != `REG_G_MEM) begin
              if ((bus_rdata_in & `OP_G_MASK) == `OP_IN_IMM) begin
                kind  <= IK_IN0;
                state <= ST_IMM;
              end else if ((bus_rdata_in & `OP_G_MASK) == `OP_OUT_IMM) begin
                kind  <= IK_OUT0;
                state <= ST_IMM;
              end else if ((bus_rdata_in & `OP_G_MASK) == `OP_REG_TEST) begin
                primary_out.f <= and_flags(primary_out.f,
                  get_reg(primary_out, bus_rdata_in[5:3]) & primary_out.a);
              end
            end
          end
          ST_IMM: begin
            special_out.instruction_address <=
              special_out.instruction_address + `STEP_WORD;
            imm <= bus_rdata_in;
            case (kind)
              IK_TSTM: begin
                primary_out.f <= and_flags(primary_out.f, bus_rdata_in & primary_out.a);
                state         <= ST_FETCH;
              end
              IK_OUT0: state <= ST_IOWR;
              default: state <= ST_IORD;
            endcase
          end
          ST_MEMRD: begin
            if (kind == IK_BLOCK) begin
              imm   <= bus_rdata_in;
              state <= ST_IOWR;
            end else begin
              primary_out.f <= and_flags(primary_out.f, bus_rdata_in & primary_out.a);
              state         <= ST_FETCH;
            end
          end
          ST_IORD: begin
            if (kind == IK_IN0) begin
              primary_out <= set_reg(primary_out, op2[5:3], bus_rdata_in);
            end else begin
              primary_out.f <= and_flags(primary_out.f, bus_rdata_in & imm);
            end
            state <= ST_FETCH;
          end
          ST_IOWR: begin
            state <= ST_FETCH;
            if (kind == IK_BLOCK) begin
              primary_out.b <= blk_b;
              {primary_out.h, primary_out.l} <= blk_dec ?
                {primary_out.h, primary_out.l} - `STEP_WORD :
                {primary_out.h, primary_out.l} + `STEP_WORD;
              primary_out.c <= blk_dec ? primary_out.c - `STEP_BYTE :
                                         primary_out.c + `STEP_BYTE;
              primary_out.f[`F_ZERO] <= (blk_b == `RST_BYTE);
              // repeat decision looks at the count after the decrement
              if (op2[`BLK_REPEAT_BIT] && (blk_b != `RST_BYTE)) begin
                state <= ST_MEMRD;
              end
            end
          end
          default: state <= ST_FETCH;
        endcase
      end else if (state == ST_SLEEP && wake_sync) begin
        // only the wake pin leaves sleep; no bus cycle runs meanwhile
        state     <= ST_FETCH;
        sleep_out <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// [dv/cpu_exec_monitor.sv]
/*
  Port-level checker for the extended-instruction core.
  Assumes it is bound to the core and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_exec_monitor
  import cpu_ext_exec_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       nrst_in,
  input wire logic       wake_in,
  input wire logic [7:0] bus_rdata_in,
  input wire logic       bus_ack_in,
  input wire logic       sys_clk_out,
  input wire bus_s       bus_out,
  input wire logic       sleep_out,
  input wire gset_s      primary_out,
  input wire special_s   special_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  // ==========================================================
  // helpers
  logic step_ack;
  assign step_ack = bus_out.req && bus_ack_in && sys_clk_out;

  // ==========================================================
  // assertions
  a_half_rate: assert property (sys_clk_out |=> !sys_clk_out ##1 sys_clk_out)
    else $error("system clock not half the input clock");
  a_io_upper_zero: assert property (bus_out.req && bus_out.io |-> bus_out.addr[15:8] == 8'h00)
    else $error("port cycle with nonzero upper address");
  a_req_hold: assert property (bus_out.req && !(bus_ack_in && sys_clk_out) |=> $stable(bus_out))
    else $error("bus request changed before acknowledge");
  a_req_drop: assert property (step_ack |=> !bus_out.req)
    else $error("request held after acknowledge");
  a_fetch_addr: assert property (bus_out.req && bus_out.m1 |->
      bus_out.addr == special_out.instruction_address)
    else $error("opcode fetch away from instruction address");
  a_fetch_count: assert property (step_ack && bus_out.m1 |=>
      special_out.instruction_address == $past(special_out.instruction_address) + 16'h0001
      && special_out.refresh[6:0] == $past(special_out.refresh[6:0]) + 7'h01
      && special_out.refresh[7] == $past(special_out.refresh[7]))
    else $error("fetch did not step address and refresh");
  a_sleep_quiet: assert property (sleep_out |-> !bus_out.req)
    else $error("bus request while sleeping");
  a_sleep_hold: assert property (sleep_out && !wake_in && !$past(wake_in) && !$past(wake_in, 2)
      && !$past(wake_in, 3) |=> sleep_out)
    else $error("sleep left without wake");
  a_wake_bound: assert property ($rose(wake_in) && sleep_out |-> ##[1:8] !sleep_out)
    else $error("wake did not end sleep");

  // ==========================================================
  // coverage
  c_io_write: cover property (step_ack && bus_out.io && bus_out.we);
  c_io_read:  cover property (step_ack && bus_out.io && !bus_out.we);
  c_wake:     cover property ($fell(sleep_out));
endmodule

`default_nettype wire

// [dv/mem_io_model.sv]
/*
  Memory and port model on the far side of the core's bus.
  Assumes the bench loads memory and port bytes and sets the latency.
*/
`timescale 1ns/1ps
`default_nettype none

module mem_io_model
  import cpu_ext_exec_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       nrst_in,
  input  wire bus_s       bus_in,
  output logic [7:0]      rdata_out,
  output logic            ack_out
);
  logic [7:0] mem     [0:1023];
  logic [7:0] io      [0:255];
  logic [7:0] wr_port [0:31];
  logic [7:0] wr_data [0:31];
  int         wr_count;
  int         lat = 0;
  int         cnt;
  logic [7:0] last;

  // ack held while the request stands, dropped once it goes
  always @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_out  <= 1'b0;
      cnt      <= 0;
      wr_count <= 0;
      last     <= 8'h00;
    end else if (!bus_in.req) begin
      ack_out <= 1'b0;
      cnt     <= 0;
    end else if (!ack_out && cnt < lat) begin
      cnt <= cnt + 1;
    end else if (!ack_out) begin
      ack_out <= 1'b1;
      last    <= bus_in.io ? io[bus_in.addr[7:0]] : mem[bus_in.addr[9:0]];
      if (bus_in.we && bus_in.io) begin
        wr_port[wr_count] <= bus_in.addr[7:0];
        wr_data[wr_count] <= bus_in.wdata;
        wr_count          <= wr_count + 1;
      end else if (bus_in.we) begin
        mem[bus_in.addr[9:0]] <= bus_in.wdata;
      end
    end
  end

  // released data shows the inverse so a stale sample cannot match
  assign rdata_out = ack_out ? last : ~last;
endmodule

`default_nettype wire

// [dv/tb_top.sv]
/*
  Self-checking bench: runs short programs ending in sleep, then
  judges the register ports and the port write log of the model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpu_ext_exec_regs.svh"

module tb_top
  import cpu_ext_exec_pkg::*;
();
  logic       ref_clk_in;
  logic       nrst_in;
  logic       wake_in;
  logic [7:0] bus_rdata_in;
  logic       bus_ack_in;
  logic       sys_clk_out;
  bus_s       bus_out;
  logic       sleep_out;
  gset_s      primary_out;
  special_s   special_out;
  int         err_count;
  int         comparisons;
  logic [7:0] prog [$];

  cpu_extended_instruction_exec dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .wake_in(wake_in), .bus_rdata_in(bus_rdata_in), .bus_ack_in(bus_ack_in),
    .sys_clk_out(sys_clk_out), .bus_out(bus_out), .sleep_out(sleep_out),
    .primary_out(primary_out), .special_out(special_out));
  mem_io_model mem_io (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .bus_in(bus_out),
    .rdata_out(bus_rdata_in), .ack_out(bus_ack_in));

  // ==========================================================
  // helpers
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic [7:0] tflags(input logic [7:0] r);
    return {r[7], r == 8'h00, 1'b0, 1'b1, 1'b0, ~^r, 2'b00};
  endfunction

  task automatic ed(input logic [7:0] op);
    prog.push_back(`OP_PREFIX);
    prog.push_back(op);
  endtask

  // loads register g from its own port 10h+g
  task automatic ld(input logic [2:0] g, input logic [7:0] v);
    mem_io.io[8'h10 + g] = v;
    ed(`OP_IN_IMM | {2'b00, g, 3'b000});
    prog.push_back(8'h10 + g);
  endtask

  task automatic wait_sleep(input logic lvl);
    for (int i = 0; i < 4000 && sleep_out !== lvl; i++) @(negedge ref_clk_in);
    if (sleep_out !== lvl) begin
      err_count++;
      $display("[ERR] sleep_out expected %b seen %b", lvl, sleep_out);
      complete_run();
    end
  endtask

  task automatic run_prog();
    ed(`OP_SLEEP);
    foreach (prog[k]) mem_io.mem[k] = prog[k];
    prog.delete();
    @(posedge ref_clk_in);
    nrst_in <= 1'b0;
    repeat (6) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    wait_sleep(1'b1);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_sleep();
    ed(`OP_SLEEP);
    run_prog();
    chk("vector_base", 16'h0000, special_out.vector_base);
    chk("stack_top", 16'h0000, special_out.stack_top);
    chk("refresh", 16'h0002, special_out.refresh);
    chk("accumulator", 16'h0000, primary_out.a);
    repeat (20) @(negedge ref_clk_in);
    chk("sleep held", 16'h0001, sleep_out);
    chk("sleep pc", 16'h0002, special_out.instruction_address);
    @(posedge ref_clk_in);
    wake_in <= 1'b1;
    wait_sleep(1'b0);
    @(posedge ref_clk_in);
    wake_in <= 1'b0;
    wait_sleep(1'b1);
    chk("wake pc", 16'h0004, special_out.instruction_address);
  endtask

  task automatic t_mult();
    logic [7:0]  hv [3];
    logic [7:0]  lv [3];
    logic [15:0] got;
    hv = '{8'hff, 8'h12, 8'h80};
    lv = '{8'hff, 8'h34, 8'h02};
    for (int k = 0; k < 3; k++) begin
      ld(3'(2 * k), hv[k]);
      ld(3'(2 * k + 1), lv[k]);
      ed(`OP_MUL | 8'(k << 4));
      run_prog();
      got = k == 0 ? {primary_out.b, primary_out.c} :
            k == 1 ? {primary_out.d, primary_out.e} : {primary_out.h, primary_out.l};
      chk("product", {8'h00, hv[k]} * {8'h00, lv[k]}, got);
    end
    ed(`OP_MUL | 8'h30);
    run_prog();
    chk("stack product", 16'h0000, special_out.stack_top);
  endtask

  task automatic t_block();
    logic [7:0] ops [4];
    logic [7:0] s;
    logic [7:0] a;
    int         n;
    ops = '{8'h83, 8'h8b, 8'h93, 8'h9b};
    for (int i = 8'h78; i < 8'h88; i++) mem_io.mem[i] = 8'(8'ha0 + i);
    mem_io.lat = 3;
    for (int k = 0; k < 4; k++) begin
      ld(3'h0, 8'h03);
      ld(3'h1, 8'h40);
      ld(3'h5, 8'h80);
      ed(ops[k]);
      run_prog();
      n = ops[k][4] ? 3 : 1;
      s = ops[k][3] ? 8'hff : 8'h01;
      chk("block writes", 16'(n), 16'(mem_io.wr_count));
      for (int j = 0; j < n; j++) begin
        a = 8'h80 + 8'(s * j);
        chk("block port", 8'(8'h40 + 8'(s * j)), mem_io.wr_port[j]);
        chk("block data", 8'(8'ha0 + a), mem_io.wr_data[j]);
      end
      chk("block count", 16'(3 - n), primary_out.b);
      chk("block port byte", 8'(8'h40 + 8'(s * n)), primary_out.c);
      chk("block pointer", 16'h0080 + 16'(s[7] ? -n : n), {primary_out.h, primary_out.l});
      chk("block zero", 16'(n == 3), primary_out.f[`F_ZERO]);
    end
    mem_io.lat = 0;
  endtask

  task automatic t_port();
    ld(3'h7, 8'h5a);
    ed(`OP_OUT_IMM | 8'h38);
    prog.push_back(8'h30);
    run_prog();
    chk("out writes", 16'h0001, 16'(mem_io.wr_count));
    chk("out port", 16'h0030, mem_io.wr_port[0]);
    chk("out data", 16'h005a, mem_io.wr_data[0]);
    chk("in value", 16'h005a, primary_out.a);
    chk("in flags", 16'h0000, primary_out.f);
  endtask

  task automatic t_tests();
    logic [7:0] exp [4];
    exp = '{8'h0c, 8'h00, 8'h0d, 8'h03};
    mem_io.io[8'h21] = 8'hc3;
    for (int k = 0; k < 4; k++) begin
      ld(3'h7, 8'h0f);
      ld(3'h0, 8'h3c);
      ld(3'h1, 8'h21);
      case (k)
        0: ed(`OP_REG_TEST);
        1: begin
          ed(`OP_IMM_TEST);
          prog.push_back(8'hf0);
        end
        2: ed(`OP_MEM_TEST);
        default: begin
          ed(`OP_PORT_TEST);
          prog.push_back(8'h33);
        end
      endcase
      run_prog();
      chk("test flags", tflags(exp[k]), primary_out.f);
      chk("test acc", 16'h000f, primary_out.a);
      chk("test reg", 16'h003c, primary_out.b);
      chk("test writes", 16'h0000, 16'(mem_io.wr_count));
      chk("test memory", 16'h00ed, mem_io.mem[0]);
    end
  endtask

  task automatic t_swap();
    ld(3'h7, 8'h5a);
    prog.push_back(`OP_SWAP_AF);
    // second loads use their own ports so the first values survive
    mem_io.io[8'h27] = 8'h11;
    ed(`OP_IN_IMM | 8'h38);
    prog.push_back(8'h27);
    prog.push_back(`OP_SWAP_AF);
    ld(3'h0, 8'h77);
    prog.push_back(`OP_SWAP_GEN);
    mem_io.io[8'h28] = 8'h22;
    ed(`OP_IN_IMM);
    prog.push_back(8'h28);
    prog.push_back(`OP_SWAP_GEN);
    run_prog();
    chk("swap acc", 16'h005a, primary_out.a);
    chk("swap pair", 16'h0077, primary_out.b);
  endtask

  // ==========================================================
  // sequence
  initial begin
    ref_clk_in  = 1'b0;
    nrst_in     = 1'b0;
    wake_in     = 1'b0;
    err_count   = 0;
    comparisons = 0;
    t_sleep();
    t_mult();
    t_block();
    t_port();
    t_tests();
    t_swap();
    complete_run();
  end

  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end
endmodule

bind cpu_extended_instruction_exec cpu_exec_monitor u_mon (.ref_clk_in(ref_clk_in),
  .nrst_in(nrst_in), .wake_in(wake_in), .bus_rdata_in(bus_rdata_in),
  .bus_ack_in(bus_ack_in), .sys_clk_out(sys_clk_out), .bus_out(bus_out),
  .sleep_out(sleep_out), .primary_out(primary_out), .special_out(special_out));

`default_nettype wire
